// [inc/cfg_pkg.sv]
// package: address-space configuration constants and carrier types
package cfg_pkg;

    // five-bit processor mode encodings
    localparam logic [4:0] MODE_USR26 = 5'h00;
    localparam logic [4:0] MODE_LEGACY_FIQ = 5'h01;
    localparam logic [4:0] MODE_LEGACY_IRQ = 5'h02;
    localparam logic [4:0] MODE_SVC26 = 5'h03;
    localparam logic [4:0] MODE_USR32 = 5'h10;
    localparam logic [4:0] MODE_FIQ32 = 5'h11;
    localparam logic [4:0] MODE_IRQ32 = 5'h12;
    localparam logic [4:0] MODE_SVC32 = 5'h13;
    localparam logic [4:0] MODE_ABT32 = 5'h17;
    localparam logic [4:0] MODE_UND32 = 5'h1b;

    // reset values
    localparam logic [4:0] RESET_MODE    = 5'h03;
    localparam logic [1:0] RESET_CONFIG  = 2'h0;

    // configuration codes {program_space_wide, data_space_wide}
    localparam logic [1:0] CFG_ALL26   = 2'h0;
    localparam logic [1:0] CFG_WIDE_DATA = 2'h1;
    localparam logic [1:0] CFG_ILLEGAL = 2'h2;
    localparam logic [1:0] CFG_ALL32   = 2'h3;

    // exception kinds
    typedef enum logic [2:0] {
        EXC_RESET   = 3'h0,
        EXC_UNDEF   = 3'h1,
        EXC_SWI     = 3'h2,
        EXC_PABORT  = 3'h3,
        EXC_DABORT  = 3'h4,
        EXC_ADDRESS = 3'h5,
        EXC_IRQ     = 3'h6,
        EXC_FIQ     = 3'h7
    } exc_type;

    typedef struct packed {
        logic       valid;
        logic [4:0] mode;
    } mode_req_type;

    typedef struct packed {
        logic    valid;
        exc_type kind;
    } exc_req_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
    } data_req_type;

    typedef struct packed {
        logic       legacy_program;
        logic       addr_exc_enable;
        logic       config_error;
        logic [4:0] mode;
    } status_type;

endpackage : cfg_pkg

// [design/address_space_config_select.sv]
// address-space configuration select: mode gating, address exceptions, exception mode

module address_space_config_select (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   program_space_wide,
    input  wire logic                   data_space_wide,
    input  wire cfg_pkg::mode_req_type  mode_req,
    input  wire logic                   status_move,
    input  wire cfg_pkg::exc_req_type   exc_req,
    input  wire cfg_pkg::data_req_type  data_req,
    output logic [4:0]                  mode,
    output logic                        mode_refused,
    output logic                        addr_exception,
    output logic [31:0]                 data_addr,
    output logic                        data_valid,
    output cfg_pkg::status_type         status
);

    ////////////////////////////////////////////////////////////////////////////
    // configuration capture

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_RUN   = 2'b01
    } state_type;

    state_type  state_q, state_d;
    logic [1:0] cfg_q, cfg_d;

    // straps sampled while reset holds and once more on the first clock after release; later changes are ignored
    always_comb
    begin
        state_d = state_q;
        cfg_d   = cfg_q;
        case (state_q)
            ST_RESET:
            begin
                cfg_d   = {program_space_wide, data_space_wide};
                state_d = ST_RUN;
            end
            ST_RUN:
            begin
                state_d = ST_RUN;
            end
            default:
            begin
                state_d = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= ST_RESET;
            cfg_q   <= {program_space_wide, data_space_wide};
        end
        else
        begin
            state_q <= state_d;
            cfg_q   <= cfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode

    logic legacy_prog;
    logic addr_exc_en;
    logic cfg_bad;

    // illegal combination treated as all-26, the safest reading
    assign legacy_prog = (cfg_q != cfg_pkg::CFG_ALL32);
    assign addr_exc_en = (cfg_q == cfg_pkg::CFG_ALL26) || (cfg_q == cfg_pkg::CFG_ILLEGAL);
    assign cfg_bad     = (cfg_q == cfg_pkg::CFG_ILLEGAL);

    function automatic logic mode_legal(input logic [4:0] m, input logic legacy);
        logic is26;
        logic is32;
        is26 = (m == cfg_pkg::MODE_USR26) || (m == cfg_pkg::MODE_LEGACY_FIQ)
            || (m == cfg_pkg::MODE_LEGACY_IRQ) || (m == cfg_pkg::MODE_SVC26);
        is32 = (m == cfg_pkg::MODE_USR32) || (m == cfg_pkg::MODE_FIQ32)
            || (m == cfg_pkg::MODE_IRQ32) || (m == cfg_pkg::MODE_SVC32)
            || (m == cfg_pkg::MODE_ABT32) || (m == cfg_pkg::MODE_UND32);
        mode_legal = legacy ? is26 : (is26 || is32);
    endfunction : mode_legal

    function automatic logic [4:0] exc_mode(input cfg_pkg::exc_type k, input logic legacy);
        logic [4:0] m;
        case (k)
            cfg_pkg::EXC_FIQ:    m = cfg_pkg::MODE_FIQ32;
            cfg_pkg::EXC_IRQ:    m = cfg_pkg::MODE_IRQ32;
            cfg_pkg::EXC_PABORT: m = cfg_pkg::MODE_ABT32;
            cfg_pkg::EXC_DABORT: m = cfg_pkg::MODE_ABT32;
            cfg_pkg::EXC_UNDEF:  m = cfg_pkg::MODE_UND32;
            default:             m = cfg_pkg::MODE_SVC32;
        endcase
        // legacy cores have no abort/undef modes: those land in supervisor
        if (legacy)
        begin
            case (k)
                cfg_pkg::EXC_FIQ: m = cfg_pkg::MODE_LEGACY_FIQ;
                cfg_pkg::EXC_IRQ: m = cfg_pkg::MODE_LEGACY_IRQ;
                default:          m = cfg_pkg::MODE_SVC26;
            endcase
        end
        exc_mode = m;
    endfunction : exc_mode

    ////////////////////////////////////////////////////////////////////////////
    // mode and data path

    logic [4:0]  mode_q, mode_d;
    logic        refused_q, refused_d;
    logic        aexc_q, aexc_d;
    logic [31:0] daddr_q, daddr_d;
    logic        dvalid_q, dvalid_d;
    logic        over26;

    assign over26 = |data_req.addr[31:26];

    always_comb
    begin
        mode_d    = mode_q;
        refused_d = 1'b0;
        aexc_d    = 1'b0;
        daddr_d   = daddr_q;
        dvalid_d  = 1'b0;
        if (state_q == ST_RUN)
        begin
            if (data_req.valid)
            begin
                if (addr_exc_en && over26)
                begin
                    aexc_d = 1'b1;
                end
                else
                begin
                    daddr_d  = data_req.addr;
                    dvalid_d = 1'b1;
                end
            end
            // exceptions take priority over a mode write in the same cycle
            if (exc_req.valid)
            begin
                mode_d = exc_mode(exc_req.kind, legacy_prog);
            end
            else if (aexc_d)
            begin
                mode_d = exc_mode(cfg_pkg::EXC_ADDRESS, legacy_prog);
            end
            else if (mode_req.valid)
            begin
                // status moves use the same legality check as any other write
                if (mode_legal(mode_req.mode, legacy_prog))
                begin
                    mode_d = mode_req.mode;
                end
                else
                begin
                    refused_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mode_q    <= cfg_pkg::RESET_MODE;
            refused_q <= 1'b0;
            aexc_q    <= 1'b0;
            daddr_q   <= 32'h0000_0000;
            dvalid_q  <= 1'b0;
        end
        else
        begin
            mode_q    <= mode_d;
            refused_q <= refused_d;
            aexc_q    <= aexc_d;
            daddr_q   <= daddr_d;
            dvalid_q  <= dvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status register

    cfg_pkg::status_type status_q, status_d;

    always_comb
    begin
        status_d.legacy_program  = legacy_prog;
        status_d.addr_exc_enable = addr_exc_en;
        status_d.config_error    = cfg_bad;
        status_d.mode            = mode_d;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            status_q <= '{1'b1, 1'b1, 1'b0, cfg_pkg::RESET_MODE};
        end
        else
        begin
            status_q <= status_d;
        end
    end

    assign mode           = mode_q;
    assign mode_refused   = refused_q;
    assign addr_exception = aexc_q;
    assign data_addr      = daddr_q;
    assign data_valid     = dvalid_q;
    assign status         = status_q;

    // status_move is accepted as a hint only; behaviour is identical
    logic unused_move;
    assign unused_move = status_move;

endmodule : address_space_config_select

// [tb/cfg_monitor.sv]
// checker: configuration rules seen at the core's ports
module cfg_monitor (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  program_space_wide,
    input wire logic                  data_space_wide,
    input wire cfg_pkg::mode_req_type mode_req,
    input wire cfg_pkg::exc_req_type  exc_req,
    input wire cfg_pkg::data_req_type data_req,
    input wire logic [4:0]            mode,
    input wire logic                  mode_refused,
    input wire logic                  addr_exception,
    input wire logic [31:0]           data_addr,
    input wire logic                  data_valid,
    input wire cfg_pkg::status_type   status
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    sequence s_mode_only;
        mode_req.valid && !exc_req.valid && !data_req.valid;
    endsequence
    sequence s_data_only;
        data_req.valid && !exc_req.valid;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_refuse_wide_mode: assert property (s_mode_only ##0 (!program_space_wide && mode_req.mode[4])
        |=> mode_refused && mode == $past(mode)) else $error("wide mode taken");
    a_exc_legacy_mode: assert property (exc_req.valid && !program_space_wide |=> !mode[4])
        else $error("exception left legacy modes");
    a_wide_mode_accept: assert property (s_mode_only ##0 (program_space_wide
        && mode_req.mode inside {5'h03, 5'h10, 5'h12, 5'h17, 5'h1b})
        |=> mode == $past(mode_req.mode) && !mode_refused) else $error("legal mode refused");
    a_addr_exc_raised: assert property (s_data_only ##0 (!program_space_wide && !data_space_wide
        && data_req.addr[31:26] != 6'h00) |=> addr_exception && !data_valid) else $error("no address exception");
    a_data_full_reach: assert property (s_data_only ##0 data_space_wide
        |=> data_valid && !addr_exception && data_addr == $past(data_req.addr)) else $error("data reach cut");
    a_status_mirror: assert property (rst_n[*3]
        |-> status.mode == mode && status.legacy_program == !program_space_wide) else $error("status stale");
endmodule : cfg_monitor

bind address_space_config_select cfg_monitor u_cfg_monitor (.clk(clk), .rst_n(rst_n),
    .program_space_wide(program_space_wide), .data_space_wide(data_space_wide), .mode_req(mode_req),
    .exc_req(exc_req), .data_req(data_req), .mode(mode), .mode_refused(mode_refused),
    .addr_exception(addr_exception), .data_addr(data_addr), .data_valid(data_valid), .status(status));

// [tb/strap_model.sv]
// partner model: board straps for the two width inputs
module strap_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] cfg_sel,
    output logic            program_space_wide,
    output logic            data_space_wide
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] strap_q = 2'h0;
    // straps move only under reset, and never to the illegal pairing
    always_ff @(posedge clk)
    begin
        if (!rst_n && cfg_sel != cfg_pkg::CFG_ILLEGAL)
            strap_q <= cfg_sel;
    end
    assign {program_space_wide, data_space_wide} = strap_q;
endmodule : strap_model

// [tb/tb_top.sv]
// testbench: random and corner requests under each legal strap setting
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] cfg_sel = 2'h0;
    logic program_space_wide;
    logic data_space_wide;
    cfg_pkg::mode_req_type mode_req = '0;
    logic status_move = 1'b0;
    cfg_pkg::exc_req_type exc_req = '0;
    cfg_pkg::data_req_type data_req = '0;
    logic [4:0] mode;
    logic mode_refused;
    logic addr_exception;
    logic [31:0] data_addr;
    logic data_valid;
    cfg_pkg::status_type status;
    int fail_count = 0;
    int tests_run = 0;
    logic [4:0] exp_mode;
    logic [4:0] codes [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1b};
    strap_model u_strap_model (.clk(clk), .rst_n(rst_n), .cfg_sel(cfg_sel),
        .program_space_wide(program_space_wide), .data_space_wide(data_space_wide));
    address_space_config_select u_address_space_config_select (.clk(clk), .rst_n(rst_n),
        .program_space_wide(program_space_wide), .data_space_wide(data_space_wide), .mode_req(mode_req),
        .status_move(status_move), .exc_req(exc_req), .data_req(data_req), .mode(mode), .mode_refused(mode_refused),
        .addr_exception(addr_exception), .data_addr(data_addr), .data_valid(data_valid), .status(status));
    initial
    begin
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic legal(input logic w, input logic [4:0] v);
        return v < 5'h04 || (w && v inside {5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1b});
    endfunction : legal
    // narrow program space funnels every exception into 26-bit modes
    function automatic logic [4:0] target(input logic w, input logic [2:0] t);
        case (t)
            3'h6: return w ? 5'h12 : 5'h02;
            3'h7: return w ? 5'h11 : 5'h01;
            3'h1: return w ? 5'h1b : 5'h03;
            3'h3, 3'h4: return w ? 5'h17 : 5'h03;
            default: return w ? 5'h13 : 5'h03;
        endcase
    endfunction : target
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////
    task automatic run_cfg(input logic [1:0] c);
        logic w;
        logic [1:0] op;
        logic [4:0] m;
        logic [2:0] k;
        logic [31:0] a;
        logic ae;
        w = c[1];
        @(posedge clk);
        cfg_sel <= c;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        exp_mode = 5'h03;
        for (int i = 0; i < 60; i++)
        begin
            op = i < 10 ? 2'h0 : i < 18 ? 2'h1 : i < 20 ? 2'h2 : 2'($urandom_range(0, 2));
            m = i < 10 ? codes[i] : 5'($urandom);
            k = i < 18 ? 3'(i - 10) : 3'($urandom);
            // the address trap kind is driven only with narrow program space; wide runs send IRQ instead
            if (w && k == 3'h5)
                k = 3'h6;
            a = i == 18 ? 32'h03ff_ffff : i == 19 ? 32'h0400_0000 : $urandom;
            @(posedge clk);
            mode_req <= {op == 2'h0, m};
            status_move <= 1'($urandom);
            exc_req <= {op == 2'h1, k};
            data_req <= {op == 2'h2, 1'($urandom), a};
            @(posedge clk);
            mode_req.valid <= 1'b0;
            exc_req.valid <= 1'b0;
            data_req.valid <= 1'b0;
            #1;
            ae = c == 2'h0 && a[31:26] != 6'h00;
            if (op == 2'h2)
            begin
                check("addr_exception", 32'(ae), 32'(addr_exception));
                check("data_valid", 32'(!ae), 32'(data_valid));
                if (!ae)
                    check("data_addr", a, data_addr);
                else
                    exp_mode = target(w, 3'h5);
            end
            else if (op == 2'h1)
                exp_mode = target(w, k);
            else
            begin
                check("mode_refused", 32'(!legal(w, m)), 32'(mode_refused));
                if (legal(w, m))
                    exp_mode = m;
            end
            check("mode", 32'(exp_mode), 32'(mode));
        end
        check("status", 32'({!w, c == 2'h0, 1'b0, exp_mode}), 32'(status));
        $display("test cfg %h done", c);
    endtask : run_cfg
    initial
    begin
        void'($urandom(32'h4455a140));
        run_cfg(2'h0);
        run_cfg(2'h1);
        run_cfg(2'h3);
        give_verdict();
    end
endmodule : tb_top
